// [design/afebg_bank.v]
// Byte-wide configuration bank for analog front end bias, gains and output DAC
`timescale 1ns/100ps
`include "afebg_regs.vh"
module afebg_bank (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [`AFEBG_ADDR_W-1:0] addr_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] wdata_i,
  output wire [7:0] rdata_o,
  output wire rvalid_o,
  output wire [1:0] common_mode_bias_level_o,
  output wire common_mode_bias_enable_o,
  output wire [1:0] aux_input_gain_o,
  output wire [1:0] temp_sense_gain_o,
  output wire third_stage_invert_o,
  output wire [15:0] dac_code_o,
  output wire dac_output_connect_o,
  output wire dac_ratiometric_o
);

  // Register select codes; one decode feeds both read and write
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_BIAS = 3'h1;
  localparam [2:0] SEL_AUX = 3'h2;
  localparam [2:0] SEL_TEMP = 3'h3;
  localparam [2:0] SEL_DAC_LO = 3'h4;
  localparam [2:0] SEL_DAC_HI = 3'h5;
  localparam [2:0] SEL_DAC_CTRL = 3'h6;
  localparam [2:0] SEL_DAC_CFG = 3'h7;

  // Field state
  reg [1:0] common_mode_bias_level_q;
  reg [1:0] common_mode_bias_level_d;
  reg common_mode_bias_enable_q;
  reg common_mode_bias_enable_d;
  reg [1:0] aux_input_gain_q;
  reg [1:0] aux_input_gain_d;
  reg [1:0] temp_sense_gain_q;
  reg [1:0] temp_sense_gain_d;
  reg third_stage_invert_q;
  reg third_stage_invert_d;
  reg [7:0] dac_code_lo_q;
  reg [7:0] dac_code_lo_d;
  reg [7:0] dac_code_hi_q;
  reg [7:0] dac_code_hi_d;
  reg dac_output_connect_q;
  reg dac_output_connect_d;
  reg dac_ratiometric_q;
  reg dac_ratiometric_d;

  // Read return state
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;
  reg rvalid_q;
  reg rvalid_d;

  // Full address compare; partial decode would alias stray writes
  function [2:0] addr_select;
    input [`AFEBG_ADDR_W-1:0] a;
    begin
      addr_select = SEL_NONE;
      if (a == `AFEBG_ADDR_BIAS) begin
        addr_select = SEL_BIAS;
      end else if (a == `AFEBG_ADDR_AUX) begin
        addr_select = SEL_AUX;
      end else if (a == `AFEBG_ADDR_TEMP) begin
        addr_select = SEL_TEMP;
      end else if (a == `AFEBG_ADDR_DAC_LO) begin
        addr_select = SEL_DAC_LO;
      end else if (a == `AFEBG_ADDR_DAC_HI) begin
        addr_select = SEL_DAC_HI;
      end else if (a == `AFEBG_ADDR_DAC_CTRL) begin
        addr_select = SEL_DAC_CTRL;
      end else if (a == `AFEBG_ADDR_DAC_CFG) begin
        addr_select = SEL_DAC_CFG;
      end
    end
  endfunction

  // Read mux; unmapped addresses and reserved bits return zero
  function [7:0] read_byte;
    input [2:0] s;
    begin
      read_byte = `AFEBG_RST_BYTE;
      if (s == SEL_BIAS) begin
        read_byte[`AFEBG_BIAS_LVL_MSB:`AFEBG_BIAS_LVL_LSB] = common_mode_bias_level_q;
        read_byte[`AFEBG_BIAS_EN_BIT] = common_mode_bias_enable_q; // [R10]
      end else if (s == SEL_AUX) begin
        read_byte[`AFEBG_AUX_GAIN_MSB:`AFEBG_AUX_GAIN_LSB] = aux_input_gain_q; // [R10]
      end else if (s == SEL_TEMP) begin
        read_byte[`AFEBG_TEMP_GAIN_MSB:`AFEBG_TEMP_GAIN_LSB] = temp_sense_gain_q;
        read_byte[`AFEBG_INV_BIT] = third_stage_invert_q; // [R10]
      end else if (s == SEL_DAC_LO) begin
        read_byte = dac_code_lo_q; // [R7]
      end else if (s == SEL_DAC_HI) begin
        read_byte = dac_code_hi_q; // [R7]
      end else if (s == SEL_DAC_CTRL) begin
        read_byte[`AFEBG_CONNECT_BIT] = dac_output_connect_q; // [R10]
      end else if (s == SEL_DAC_CFG) begin
        read_byte[`AFEBG_RATIO_BIT] = dac_ratiometric_q; // [R10]
      end
    end
  endfunction

  // Bus is on this clock, so no synchroniser is needed
  wire [2:0] sel;
  wire wr_bias;
  wire wr_aux;
  wire wr_temp;
  wire wr_dac_lo;
  wire wr_dac_hi;
  wire wr_dac_ctrl;
  wire wr_dac_cfg;

  assign sel = addr_select(addr_i);
  assign wr_bias = wr_en_i && (sel == SEL_BIAS);
  assign wr_aux = wr_en_i && (sel == SEL_AUX);
  assign wr_temp = wr_en_i && (sel == SEL_TEMP);
  assign wr_dac_lo = wr_en_i && (sel == SEL_DAC_LO);
  assign wr_dac_hi = wr_en_i && (sel == SEL_DAC_HI);
  assign wr_dac_ctrl = wr_en_i && (sel == SEL_DAC_CTRL);
  assign wr_dac_cfg = wr_en_i && (sel == SEL_DAC_CFG);

  // Only named field bits are stored; reserved bits are dropped [R10]
  always @* begin
    common_mode_bias_level_d = common_mode_bias_level_q;
    if (wr_bias) begin
      common_mode_bias_level_d = wdata_i[`AFEBG_BIAS_LVL_MSB:`AFEBG_BIAS_LVL_LSB]; // [R1]
    end
  end

  always @* begin
    common_mode_bias_enable_d = common_mode_bias_enable_q;
    if (wr_bias) begin
      common_mode_bias_enable_d = wdata_i[`AFEBG_BIAS_EN_BIT]; // [R2]
    end
  end

  always @* begin
    aux_input_gain_d = aux_input_gain_q;
    if (wr_aux) begin
      aux_input_gain_d = wdata_i[`AFEBG_AUX_GAIN_MSB:`AFEBG_AUX_GAIN_LSB]; // [R3]
    end
  end

  always @* begin
    temp_sense_gain_d = temp_sense_gain_q;
    if (wr_temp) begin
      temp_sense_gain_d = wdata_i[`AFEBG_TEMP_GAIN_MSB:`AFEBG_TEMP_GAIN_LSB]; // [R4]
    end
  end

  always @* begin
    third_stage_invert_d = third_stage_invert_q;
    if (wr_temp) begin
      third_stage_invert_d = wdata_i[`AFEBG_INV_BIT]; // [R5]
    end
  end

  // Byte halves update apart; software writes both to avoid a torn code
  always @* begin
    dac_code_lo_d = dac_code_lo_q;
    if (wr_dac_lo) begin
      dac_code_lo_d = wdata_i; // [R6] [R7]
    end
  end

  always @* begin
    dac_code_hi_d = dac_code_hi_q;
    if (wr_dac_hi) begin
      dac_code_hi_d = wdata_i; // [R6] [R7]
    end
  end

  always @* begin
    dac_output_connect_d = dac_output_connect_q;
    if (wr_dac_ctrl) begin
      dac_output_connect_d = wdata_i[`AFEBG_CONNECT_BIT]; // [R8]
    end
  end

  always @* begin
    dac_ratiometric_d = dac_ratiometric_q;
    if (wr_dac_cfg) begin
      dac_ratiometric_d = wdata_i[`AFEBG_RATIO_BIT]; // [R9]
    end
  end

  // Read sees the old value when a write lands in the same cycle
  always @* begin
    rvalid_d = rd_en_i;
    rdata_d = rdata_q;
    if (rd_en_i) begin
      rdata_d = read_byte(sel);
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      common_mode_bias_level_q <= `AFEBG_LVL_1V25; // [R1]
    end else begin
      common_mode_bias_level_q <= common_mode_bias_level_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      common_mode_bias_enable_q <= `AFEBG_RST_1B; // [R2]
    end else begin
      common_mode_bias_enable_q <= common_mode_bias_enable_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_input_gain_q <= `AFEBG_RST_2B; // [R3]
    end else begin
      aux_input_gain_q <= aux_input_gain_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_sense_gain_q <= `AFEBG_RST_2B; // [R4]
    end else begin
      temp_sense_gain_q <= temp_sense_gain_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      third_stage_invert_q <= `AFEBG_RST_1B; // [R5]
    end else begin
      third_stage_invert_q <= third_stage_invert_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_code_lo_q <= `AFEBG_RST_BYTE; // [R6]
    end else begin
      dac_code_lo_q <= dac_code_lo_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_code_hi_q <= `AFEBG_RST_BYTE; // [R6]
    end else begin
      dac_code_hi_q <= dac_code_hi_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_output_connect_q <= `AFEBG_RST_1B; // [R8]
    end else begin
      dac_output_connect_q <= dac_output_connect_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dac_ratiometric_q <= `AFEBG_RST_1B; // [R9]
    end else begin
      dac_ratiometric_q <= dac_ratiometric_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= `AFEBG_RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_q <= `AFEBG_RST_1B;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // Every output is a flop, so the analog side never sees decode glitches
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign common_mode_bias_level_o = common_mode_bias_level_q;
  assign common_mode_bias_enable_o = common_mode_bias_enable_q;
  assign aux_input_gain_o = aux_input_gain_q;
  assign temp_sense_gain_o = temp_sense_gain_q;
  assign third_stage_invert_o = third_stage_invert_q;
  assign dac_code_o = {dac_code_hi_q, dac_code_lo_q}; // [R6] [R7]
  assign dac_output_connect_o = dac_output_connect_q;
  assign dac_ratiometric_o = dac_ratiometric_q;

endmodule // afebg_bank

// [design/afebg_regs.vh]
// Register map, field positions and reset values of the bias, gain and DAC bank
// How it works
// R1: Bias register bits 1:0 pick common-mode level; codes 1.25, 0.5, 0.75, 1 V.
// R2: Bias register bit 2 enables common-mode bias ahead of stages one and two.
// R3: Aux gain register bits 7:6 pick aux input gain 1, 1.33, 2, 5 V/V.
// R4: Temperature register bits 1:0 pick sense gain 1, 1.33, 2, 5 V/V.
// R5: Temperature register bit 7 inverts the third gain stage output.
// R6: Sixteen-bit DAC code word, reset zero, drives the converter input continuously.
// R7: DAC code low byte at lower address, high byte at next address.
// R8: DAC control bit 0 connects converter output to DAC gain stage.
// R9: DAC configuration bit 0 selects ratiometric when 1, absolute when 0.
// R10: Reserved bits read zero; writes to them change no control output.
`ifndef AFEBG_REGS_VH
`define AFEBG_REGS_VH
`define AFEBG_ADDR_W 32
`define AFEBG_ADDR_BIAS 32'h4000_0528
`define AFEBG_ADDR_AUX 32'h4000_052a
`define AFEBG_ADDR_TEMP 32'h4000_052b
`define AFEBG_ADDR_DAC_LO 32'h4000_0530
`define AFEBG_ADDR_DAC_HI 32'h4000_0531
`define AFEBG_ADDR_DAC_CTRL 32'h4000_0538
`define AFEBG_ADDR_DAC_CFG 32'h4000_0539
`define AFEBG_RST_BYTE 8'h00
`define AFEBG_RST_WORD 16'h0000
`define AFEBG_RST_2B 2'h0
`define AFEBG_RST_1B 1'h0
`define AFEBG_BIAS_LVL_MSB 1
`define AFEBG_BIAS_LVL_LSB 0
`define AFEBG_BIAS_EN_BIT 2
`define AFEBG_AUX_GAIN_MSB 7
`define AFEBG_AUX_GAIN_LSB 6
`define AFEBG_TEMP_GAIN_MSB 1
`define AFEBG_TEMP_GAIN_LSB 0
`define AFEBG_INV_BIT 7
`define AFEBG_CONNECT_BIT 0
`define AFEBG_RATIO_BIT 0
`define AFEBG_LVL_1V25 2'h0
`define AFEBG_LVL_0V5 2'h1
`define AFEBG_LVL_0V75 2'h2
`define AFEBG_LVL_1V 2'h3
`endif

// [testbench/afebg_monitor.sv]
// Concurrent checks on the bias, gain and DAC bank ports
`timescale 1ns/100ps
`include "afebg_regs.vh"
module afebg_monitor (input wire ref_clk_i, input wire rst_n_i, input wire [31:0] addr_i,
  input wire wr_en_i, input wire rd_en_i, input wire [7:0] wdata_i, input wire [7:0] rdata_o,
  input wire rvalid_o, input wire [1:0] common_mode_bias_level_o,
  input wire common_mode_bias_enable_o, input wire [15:0] dac_code_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wb; wr_en_i && addr_i == `AFEBG_ADDR_BIAS; endsequence
  sequence s_rb; rd_en_i && addr_i == `AFEBG_ADDR_BIAS; endsequence
  sequence s_wl; wr_en_i && addr_i == `AFEBG_ADDR_DAC_LO; endsequence
  sequence s_wh; wr_en_i && addr_i == `AFEBG_ADDR_DAC_HI; endsequence
  a_rvalid_pulse: assert property (rd_en_i |=> rvalid_o) else $error("rvalid missing");
  a_rvalid_cause: assert property (rvalid_o |-> $past(rd_en_i)) else $error("stray rvalid");
  a_bias_level: assert property (s_wb |=> common_mode_bias_level_o == $past(wdata_i[1:0]))
    else $error("bias level");
  a_bias_enable: assert property (s_wb |=> common_mode_bias_enable_o == $past(wdata_i[2]))
    else $error("bias enable");
  a_bias_hold: assert property (!(wr_en_i && addr_i == `AFEBG_ADDR_BIAS)
    |=> $stable(common_mode_bias_level_o)) else $error("bias level moved");
  a_dac_low: assert property (s_wl |=> dac_code_o == {$past(dac_code_o[15:8]), $past(wdata_i)})
    else $error("dac low byte");
  a_dac_high: assert property (s_wh |=> dac_code_o == {$past(wdata_i), $past(dac_code_o[7:0])})
    else $error("dac high byte");
  a_bias_read: assert property (s_rb |=> rdata_o == {5'h0_0, $past(common_mode_bias_enable_o),
    $past(common_mode_bias_level_o)}) else $error("bias readback");
endmodule // afebg_monitor
bind afebg_bank afebg_monitor afebg_monitor_i (.*);

// [testbench/testbench.sv]
// Testbench for the bias, gain and DAC bank
`timescale 1ns/100ps
`include "afebg_regs.vh"
module testbench;
  reg ref_clk_i = 0, rst_n_i = 0, wr = 0, rd = 0;
  reg [31:0] ad = 0;
  reg [7:0] wd = 0;
  integer failures = 0, checks = 0, k;
  wire [7:0] rdat;
  wire rv, en, inv, con, rat;
  wire [1:0] lvl, aux, tg;
  wire [15:0] dac;
  always #12.5 ref_clk_i = ~ref_clk_i;
  afebg_bank afebg_bank_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(ad), .wr_en_i(wr),
    .rd_en_i(rd), .wdata_i(wd), .rdata_o(rdat), .rvalid_o(rv), .common_mode_bias_level_o(lvl),
    .common_mode_bias_enable_o(en), .aux_input_gain_o(aux), .temp_sense_gain_o(tg),
    .third_stage_invert_o(inv), .dac_code_o(dac), .dac_output_connect_o(con),
    .dac_ratiometric_o(rat));
  task chk(input [63:0] n, input [25:0] s, input [25:0] e); begin
    checks = checks + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("MISMATCH %0s exp %h seen %h", n, e, s);
    end end endtask
  task wr8(input [31:0] a, input [7:0] d); begin
    @(negedge ref_clk_i); ad = a; wd = d; wr = 1;
    @(negedge ref_clk_i); wr = 0; end endtask
  task rd8(input [31:0] a, input [7:0] e); begin
    @(negedge ref_clk_i); ad = a; rd = 1;
    @(negedge ref_clk_i); rd = 0;
    chk("rvalid", rv, 1);
    chk("rdata", rdat, e); end endtask
  task tally_and_finish; begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish; end endtask
  initial begin
    #20000; failures = failures + 1; tally_and_finish; end
  initial begin
    repeat (20) @(negedge ref_clk_i);
    rst_n_i = 1;
    chk("resets", {lvl, en, aux, tg, inv, dac, con, rat}, 0);
    for (k = 0; k < 4; k = k + 1) begin
      wr8(`AFEBG_ADDR_BIAS, {5'h1f, k[0], k[1:0]});
      chk("bias", {en, lvl}, {k[0], k[1:0]});
      rd8(`AFEBG_ADDR_BIAS, {5'h0, k[0], k[1:0]});
      wr8(`AFEBG_ADDR_AUX, {k[1:0], 6'h3f});
      wr8(`AFEBG_ADDR_TEMP, {k[0], 5'h1f, k[1:0]});
      chk("gains", {aux, tg, inv}, {k[1:0], k[1:0], k[0]});
      rd8(`AFEBG_ADDR_AUX, {k[1:0], 6'h0});
      rd8(`AFEBG_ADDR_TEMP, {k[0], 5'h0, k[1:0]});
    end
    wr8(`AFEBG_ADDR_DAC_LO, 8'ha5);
    chk("daclo", dac, 16'h00a5);
    wr8(`AFEBG_ADDR_DAC_HI, 8'h3c);
    chk("dac", dac, 16'h3ca5);
    rd8(`AFEBG_ADDR_DAC_HI, 8'h3c);
    rd8(`AFEBG_ADDR_DAC_LO, 8'ha5);
    wr8(`AFEBG_ADDR_DAC_CTRL, 8'hff);
    wr8(`AFEBG_ADDR_DAC_CFG, 8'hfe);
    chk("dacmode", {con, rat}, 2'h2);
    rd8(`AFEBG_ADDR_DAC_CTRL, 8'h01);
    rd8(`AFEBG_ADDR_DAC_CFG, 8'h00);
    wr8(32'h4000_0529, 8'h00);
    chk("unmapped", {en, lvl}, 3'h7);
    rd8(32'h4000_0529, 8'h00);
    tally_and_finish;
  end
endmodule // testbench
